// File: bench/tcb_capture_tb.sv
// Self-checking bench for the curve buffer capture block
`timescale 1ns/1ps
`default_nettype none
module tcb_capture_tb;
  import tcb_pkg::*;
  logic hclk, hresetn, hwrite, trig_lvl, trig, hreadyout, hresp, running;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [127:0] fast_data;
  logic [255:0] std_data;
  int errors, samples_checked, cyc;

  // ==========================================================================
  // Clock, partner, design
  // ==========================================================================
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  tcb_trig_src src_u (.lvl(trig_lvl), .trig(trig));
  tcb_capture dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_trigger_input(trig),
    .fast_data(fast_data), .std_data(std_data), .running(running));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Called just after a rising edge; waits on hready, no fixed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    logic r;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do
    begin
      @(negedge hclk) r = hreadyout;
      @(posedge hclk);
    end
    while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
      @(posedge hclk);
    end
    while (r !== 1'b1);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk("register", q, exp);
  endtask : rd

  // Trigger edge lands 3 edges after the pin, state 1 edge later
  task automatic pin(input logic v);
    trig_lvl <= v;
    repeat (8) @(posedge hclk);
  endtask : pin

  task automatic end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    trig_lvl = 1'b0;
    fast_data = 128'ha007_a006_a005_a004_a003_a002_a001_a000;
    // Distinct curve values expose a wrong curve index or slot
    for (int k = 0; k < 16; k++) std_data[k*16 +: 16] = 16'h5a50 + 16'(k);
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CTRL, 32'h10);
    rd(OFS_LEN, 32'(BUF_POINTS));
    rd(OFS_POINTS, 32'h0);
    rd(8'h40, 32'h0);
    wr(OFS_TPP, 32'h0);
    rd(OFS_TPP, {12'h0, TPP_MIN});
    wr(OFS_TPP, 32'h00200000);
    rd(OFS_TPP, {12'h0, TPP_MAX});
    wr(OFS_TPP, 32'h1);
    // Fast sweep of four points, internal start, stop when full
    wr(OFS_CTRL, 32'h11);
    wr(OFS_LEN, 32'h4);
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS, 32'h2);
    for (int i = 0; i < 2000 && running !== 1'b0; i++) @(posedge hclk);
    rd(OFS_POINTS, 32'h4);
    rd(OFS_SWEEPS, 32'h1);
    wr(OFS_RDADDR, 32'h04000000);
    rd(OFS_RDDATA, 32'ha004);
    // Fast dual sweep stores all eight lanes
    wr(OFS_CTRL, 32'h13);
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS, 32'h2);
    for (int i = 0; i < 2000 && running !== 1'b0; i++) @(posedge hclk);
    wr(OFS_RDADDR, 32'h07000000);
    rd(OFS_RDDATA, 32'ha007);
    // Rising start, command stop, arm and start refused in run
    wr(OFS_CTRL, 32'h05);
    wr(OFS_CMD, 32'h1);
    rd(OFS_STATUS, 32'h1);
    pin(1'b1);
    rd(OFS_STATUS, 32'h6);
    wr(OFS_CMD, 32'h3);
    rd(OFS_STATUS, 32'h6);
    wr(OFS_CMD, 32'h4);
    rd(OFS_STATUS, 32'h4);
    // Falling start, rising stop; edges while idle do nothing
    wr(OFS_CTRL, 32'h29);
    pin(1'b0);
    rd(OFS_STATUS, 32'h0);
    pin(1'b1);
    wr(OFS_CMD, 32'h1);
    pin(1'b0);
    rd(OFS_STATUS, 32'h2);
    pin(1'b1);
    rd(OFS_STATUS, 32'h4);
    // Internal start, falling stop
    wr(OFS_CTRL, 32'h31);
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS, 32'h6);
    pin(1'b0);
    rd(OFS_STATUS, 32'h0);
    // Standard mode length split among curves
    wr(OFS_CTRL, 32'h10);
    wr(OFS_LEN, 32'(BUF_POINTS));
    wr(OFS_CSEL, 32'hffff);
    rd(OFS_EFFLEN, 32'(BUF_POINTS / 16));
    wr(OFS_CSEL, 32'h3);
    rd(OFS_EFFLEN, 32'(BUF_POINTS / 2));
    // Standard capture of one point on two curves, then command stop
    wr(OFS_CTRL, 32'h00);
    wr(OFS_CMD, 32'h2);
    @(negedge hclk);
    chk("running", {31'h0, running}, 32'h1);
    repeat (30) @(posedge hclk);
    wr(OFS_CMD, 32'h4);
    rd(OFS_POINTS, 32'h1);
    @(negedge hclk);
    chk("running", {31'h0, running}, 32'h0);
    @(posedge hclk);
    wr(OFS_RDADDR, 32'(BUF_POINTS / 2));
    rd(OFS_RDDATA, 32'h5a51);
    wr(OFS_RDADDR, 32'h0);
    rd(OFS_RDDATA, 32'h5a50);
    end_sim();
  end
endmodule : tcb_capture_tb
`default_nettype wire

// File: bench/tcb_trig_src.sv
// Far-side model: TTL trigger source driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module tcb_trig_src #(
  parameter int DLY_NS = 7
) (
  // Requested level from the bench
  input wire logic lvl,
  // Trigger pin
  output logic trig
);
  // ==========================================================================
  // Pin
  // ==========================================================================
  // Follows the bench level by DLY_NS, and that level moves on hclk, so the edge keeps a fixed phase to hclk
  initial trig = 1'b0;
  always @(lvl) trig <= #(DLY_NS) lvl;
endmodule : tcb_trig_src
`default_nettype wire

// File: hw/tcb_capture.sv
// Curve buffer acquisition controller with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module tcb_capture
  import tcb_pkg::*;
#(
  parameter int LANE_W = 16,
  parameter int DEPTH = BUF_POINTS,
  parameter int AW = 17
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Trigger pin
  input wire logic external_trigger_input,
  // Instrument outputs
  input wire logic [FAST_LANES*LANE_W-1:0] fast_data,
  input wire logic [NCURVE_MAX*LANE_W-1:0] std_data,
  // Status
  output logic running
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (DEPTH > (2 ** AW) || DEPTH < NCURVE_MAX || AW > 21) begin : g_chk
    $error("tcb_capture: DEPTH does not fit the address width");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    tcb_state_t state;
    logic fast;
    logic dual;
    logic [1:0] start_sel;
    logic [1:0] stop_sel;
    logic [19:0] tpp;
    logic [16:0] len;
    logic [15:0] csel;
    logic [16:0] points;
    logic [31:0] sweeps;
    logic [16:0] rd_addr;
    logic [2:0] rd_lane;
    logic t1;
    logic t2;
    logic t3;
    logic rise;
    logic fall;
    logic [5:0] pre;
    logic [29:0] iv;
    logic ph_act;
    logic [3:0] ph;
    logic [3:0] slot;
    logic dp_wr;
    logic dp_hit;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } tcb_core_t;

  tcb_core_t st_r;
  tcb_core_t st_nxt;

  logic ap;
  logic wr_en;
  logic cmd_arm;
  logic cmd_start;
  logic cmd_stop;
  logic [4:0] ncurve;
  logic [16:0] cap;
  logic [16:0] eff_len;
  logic [29:0] ivl;
  logic tick;
  logic pt_done;
  logic start_edge;
  logic stop_hit;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [FAST_LANES-1:0] mem_wlanes;
  logic [FAST_LANES*LANE_W-1:0] mem_wdata;
  logic [FAST_LANES*LANE_W-1:0] mem_rdata;
  logic [31:0] rd_word;
  logic [20:0] std_addr;

  // ==========================================================================
  // Curve geometry
  // ==========================================================================
  function automatic logic [4:0] popcnt(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < NCURVE_MAX; i++) begin
      n = n + 5'(v[i]);
    end
    return n;
  endfunction : popcnt

  // Per-curve capacity; constant divisors keep this a small table
  function automatic logic [16:0] cap_for(input logic [4:0] n);
    logic [16:0] c;
    c = 17'(DEPTH);
    for (int i = 1; i <= NCURVE_MAX; i++) begin
      if (int'(n) == i) c = 17'(DEPTH / i);
    end
    return c;
  endfunction : cap_for

  always_comb
  begin
    ncurve = popcnt(st_r.csel);
    cap = st_r.fast ? 17'(DEPTH) : cap_for(ncurve);
    eff_len = (st_r.len > cap) ? cap : st_r.len;
    ivl = st_r.fast ? 30'(st_r.tpp) : 30'(st_r.tpp) * 30'(MS_US);
  end

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  always_comb
  begin
    ap = hsel && hready && htrans[1];
    wr_en = st_r.dp_wr && st_r.dp_hit;
    cmd_arm = wr_en && (st_r.dp_addr == OFS_CMD) && hwdata[CMD_ARM_BIT];
    cmd_start = wr_en && (st_r.dp_addr == OFS_CMD) && hwdata[CMD_START_BIT];
    cmd_stop = wr_en && (st_r.dp_addr == OFS_CMD) && hwdata[CMD_STOP_BIT];
    rd_word = 32'h0;
    if (haddr[31:8] == 24'h0)
    begin
      case (haddr[7:0])
        OFS_CTRL: rd_word = {26'h0, st_r.stop_sel, st_r.start_sel, st_r.dual, st_r.fast};
        OFS_TPP: rd_word = {12'h0, st_r.tpp};
        OFS_LEN: rd_word = {15'h0, st_r.len};
        OFS_CSEL: rd_word = {16'h0, st_r.csel};
        OFS_STATUS: rd_word = {29'h0, st_r.t3, st_r.state};
        OFS_POINTS: rd_word = {15'h0, st_r.points};
        OFS_SWEEPS: rd_word = st_r.sweeps;
        OFS_EFFLEN: rd_word = {15'h0, eff_len};
        OFS_RDADDR: rd_word = {5'h0, st_r.rd_lane, 7'h0, st_r.rd_addr};
        OFS_RDDATA: rd_word = 32'(mem_rdata[st_r.rd_lane*LANE_W +: LANE_W]);
        default: rd_word = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Sample timing and storage
  // ==========================================================================
  always_comb
  begin
    tick = (st_r.state == TCB_RUN) && (st_r.pre == 6'h0) && (st_r.iv == 30'h0);
    pt_done = st_r.fast ? tick : (st_r.ph_act && (st_r.ph == 4'hf));
    std_addr = 21'(st_r.slot) * 21'(eff_len) + 21'(st_r.points);
    mem_wdata = fast_data;
    mem_wdata[LANE_W-1:0] = std_data[st_r.ph*LANE_W +: LANE_W];
    if (st_r.fast)
    begin
      mem_we = tick && (st_r.points < eff_len);
      mem_waddr = AW'(st_r.points);
      mem_wlanes = st_r.dual ? LANES_DUAL : LANES_SINGLE;
      mem_wdata = fast_data;
    end
    else
    begin
      mem_we = st_r.ph_act && st_r.csel[st_r.ph] && (st_r.points < eff_len);
      mem_waddr = AW'(std_addr);
      mem_wlanes = 8'h01;
    end
  end

  tcb_mem #(
    .LANES(FAST_LANES),
    .LANE_W(LANE_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .hclk(hclk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wlanes(mem_wlanes),
    .wdata(mem_wdata),
    .raddr(AW'(st_nxt.rd_addr)), // Read ahead so RDDATA follows a fresh RDADDR
    .rdata(mem_rdata)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    st_nxt = st_r;
    // Only t2 and t3 are looked at; t1 may be metastable
    st_nxt.t1 = external_trigger_input;
    st_nxt.t2 = st_r.t1;
    st_nxt.t3 = st_r.t2;
    st_nxt.rise = st_r.t2 & ~st_r.t3;
    st_nxt.fall = ~st_r.t2 & st_r.t3;

    st_nxt.dp_wr = ap && hwrite;
    st_nxt.dp_hit = (haddr[31:8] == 24'h0);
    st_nxt.dp_addr = haddr[7:0];
    st_nxt.hrdata = (ap && !hwrite) ? rd_word : 32'h0;

    if (wr_en)
    begin
      case (st_r.dp_addr)
        OFS_CTRL:
        begin
          st_nxt.fast = hwdata[CTRL_FAST_BIT];
          st_nxt.dual = hwdata[CTRL_DUAL_BIT];
          // Code 3 is not a start setting; fall back to internal
          st_nxt.start_sel = (hwdata[CTRL_START_LSB +: 2] == 2'h3) ? START_INT
                           : hwdata[CTRL_START_LSB +: 2];
          st_nxt.stop_sel = hwdata[CTRL_STOP_LSB +: 2];
        end
        OFS_TPP:
        begin
          // Clamped on write so software cannot program an illegal interval
          if (hwdata[31:0] < 32'(TPP_MIN)) st_nxt.tpp = TPP_MIN;
          else if (hwdata[31:0] > 32'(TPP_MAX)) st_nxt.tpp = TPP_MAX;
          else st_nxt.tpp = hwdata[19:0];
        end
        OFS_LEN:
        begin
          if (hwdata[31:0] == 32'h0) st_nxt.len = 17'h1;
          else if (hwdata[31:0] > 32'(DEPTH)) st_nxt.len = 17'(DEPTH);
          else st_nxt.len = hwdata[16:0];
        end
        OFS_CSEL: st_nxt.csel = (hwdata[15:0] == 16'h0) ? CSEL_RST : hwdata[15:0];
        OFS_RDADDR:
        begin
          st_nxt.rd_addr = hwdata[16:0];
          st_nxt.rd_lane = hwdata[RDADDR_LANE_LSB +: 3];
        end
        default: st_nxt.rd_addr = st_r.rd_addr;
      endcase
    end

    if (st_r.state == TCB_RUN)
    begin
      if (st_r.pre == 6'(US_CYC - 1))
      begin
        st_nxt.pre = 6'h0;
        st_nxt.iv = (st_r.iv >= ivl - 30'h1) ? 30'h0 : st_r.iv + 30'h1;
      end
      else
      begin
        st_nxt.pre = st_r.pre + 6'h1;
      end
      if (tick && !st_r.fast)
      begin
        st_nxt.ph_act = 1'b1;
        st_nxt.ph = 4'h0;
        st_nxt.slot = 4'h0;
      end
      if (st_r.ph_act)
      begin
        st_nxt.ph = st_r.ph + 4'h1;
        st_nxt.slot = st_r.slot + 4'(st_r.csel[st_r.ph]);
        if (st_r.ph == 4'hf) st_nxt.ph_act = 1'b0;
      end
      if (pt_done && (st_r.points < eff_len))
      begin
        if (st_r.points + 17'h1 >= eff_len)
        begin
          st_nxt.sweeps = st_r.sweeps + 32'h1;
          // Other stop settings keep sweeping, overwriting from point zero
          st_nxt.points = (st_r.stop_sel == STOP_FULL) ? eff_len : 17'h0;
        end
        else
        begin
          st_nxt.points = st_r.points + 17'h1;
        end
      end
    end

    start_edge = ((st_r.start_sel == START_RISE) && st_r.rise)
              || ((st_r.start_sel == START_FALL) && st_r.fall);
    stop_hit = cmd_stop
            || ((st_r.stop_sel == STOP_RISE) && st_r.rise)
            || ((st_r.stop_sel == STOP_FALL) && st_r.fall)
            || ((st_r.stop_sel == STOP_FULL) && (st_r.points >= eff_len));

    case (st_r.state)
      TCB_IDLE:
      begin
        if (cmd_stop) st_nxt.state = TCB_IDLE;
        else if (cmd_start && (st_r.start_sel == START_INT)) st_nxt.state = TCB_RUN;
        else if (cmd_arm || cmd_start) st_nxt.state = TCB_ARMED;
      end
      TCB_ARMED:
      begin
        if (cmd_stop) st_nxt.state = TCB_IDLE;
        else if (start_edge || (cmd_start && (st_r.start_sel == START_INT)))
          st_nxt.state = TCB_RUN;
      end
      TCB_RUN:
      begin
        // Arm and start fall through untouched here
        if (stop_hit)
        begin
          st_nxt.state = TCB_IDLE;
          st_nxt.ph_act = 1'b0;
        end
      end
      default: st_nxt.state = TCB_IDLE;
    endcase

    if ((st_r.state != TCB_RUN) && (st_nxt.state == TCB_RUN))
    begin
      st_nxt.points = 17'h0;
      st_nxt.sweeps = 32'h0;
      st_nxt.pre = 6'h0;
      st_nxt.iv = 30'h0;
      st_nxt.ph_act = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '0;
      st_r.state <= TCB_IDLE;
      st_r.start_sel <= START_RST;
      st_r.stop_sel <= STOP_RST;
      st_r.tpp <= TPP_RST;
      st_r.len <= LEN_RST;
      st_r.csel <= CSEL_RST;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.hrdata;
  assign running = (st_r.state == TCB_RUN);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_edge_pulse;
    @(posedge hclk) disable iff (!hresetn || !ce)
    st_r.rise |=> !st_r.rise && !st_r.fall;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse too long");

  property p_rise_start;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_ARMED) && (st_r.start_sel == START_RISE) && st_r.rise && !cmd_stop
    |=> (st_r.state == TCB_RUN) && (st_r.points == 17'h0);
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("rising start missed");

  property p_fall_start;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_ARMED) && (st_r.start_sel == START_FALL) && st_r.fall && !cmd_stop
    |=> (st_r.state == TCB_RUN);
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("falling start missed");

  property p_int_start;
    @(posedge hclk) disable iff (!hresetn || !ce)
    cmd_start && !cmd_stop && (st_r.start_sel == START_INT) && (st_r.state != TCB_RUN)
    |=> (st_r.state == TCB_RUN) && (st_r.sweeps == 32'h0);
  endproperty
  a_int_start: assert property (p_int_start) else $error("internal start missed");

  property p_need_arm;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_IDLE) && !cmd_start |=> (st_r.state != TCB_RUN);
  endproperty
  a_need_arm: assert property (p_need_arm) else $error("run without arm or start");

  property p_stop_cmd;
    @(posedge hclk) disable iff (!hresetn || !ce)
    cmd_stop |=> (st_r.state == TCB_IDLE) ##1 !mem_we;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("stop command ignored");

  property p_edge_stop;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_RUN) && (((st_r.stop_sel == STOP_RISE) && st_r.rise)
      || ((st_r.stop_sel == STOP_FALL) && st_r.fall)) |=> (st_r.state == TCB_IDLE);
  endproperty
  a_edge_stop: assert property (p_edge_stop) else $error("edge stop missed");

  property p_full_stop;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_RUN) && (st_r.stop_sel == STOP_FULL) && (st_r.points == eff_len)
    |=> (st_r.state == TCB_IDLE) && (st_r.points == $past(eff_len));
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("full stop wrong");

  property p_reject;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_RUN) && (cmd_arm || cmd_start) && !stop_hit
    |=> (st_r.state == TCB_RUN) && (st_r.sweeps >= $past(st_r.sweeps));
  endproperty
  a_reject: assert property (p_reject) else $error("arm or start disturbed a run");

  property p_fast_lanes;
    @(posedge hclk) disable iff (!hresetn || !ce)
    mem_we && st_r.fast |-> (mem_wlanes == (st_r.dual ? 8'hff : 8'h1f));
  endproperty
  a_fast_lanes: assert property (p_fast_lanes) else $error("fast lane count wrong");

  property p_fit;
    @(posedge hclk) disable iff (!hresetn || !ce)
    !st_r.fast |-> (32'(eff_len) * 32'(ncurve) <= 32'(DEPTH)) && (eff_len != 17'h0);
  endproperty
  a_fit: assert property (p_fit) else $error("curves exceed buffer");

  property p_tpp_range;
    @(posedge hclk) disable iff (!hresetn || !ce)
    wr_en && (st_r.dp_addr == OFS_TPP) |=> (st_r.tpp >= TPP_MIN) && (st_r.tpp <= TPP_MAX);
  endproperty
  a_tpp_range: assert property (p_tpp_range) else $error("interval out of range");

  property p_sweep;
    @(posedge hclk) disable iff (!hresetn || !ce)
    (st_r.state == TCB_RUN) && pt_done && (st_r.points + 17'h1 == eff_len)
    |=> (st_r.sweeps == $past(st_r.sweeps) + 32'h1);
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep not counted");

endmodule : tcb_capture
`default_nettype wire

// File: hw/tcb_mem.sv
// Lane-writable sample memory with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module tcb_mem #(
  parameter int LANES = 8,
  parameter int LANE_W = 16,
  parameter int DEPTH = 100000,
  parameter int AW = 17
) (
  // Clock
  input wire logic hclk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [LANES-1:0] wlanes,
  input wire logic [LANES*LANE_W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [LANES*LANE_W-1:0] rdata
);

  // ==========================================================================
  // One array per lane so a point can store only its used outputs
  // ==========================================================================
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];
    always_ff @(posedge hclk)
    begin
      if (ce)
      begin
        if (we && wlanes[g] && (int'(waddr) < DEPTH))
        begin
          mem[waddr] <= wdata[g*LANE_W +: LANE_W];
        end
        if (int'(raddr) < DEPTH)
        begin
          rdata[g*LANE_W +: LANE_W] <= mem[raddr];
        end
      end
    end
  end

endmodule : tcb_mem
`default_nettype wire

// File: include/tcb_pkg.sv
// Shared constants and types for the triggered curve buffer capture block
package tcb_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 40;
  localparam int T_US_NS = 1000;
  localparam int US_CYC = (T_US_NS * CLK_MHZ + 999) / 1000;
  localparam int MS_US = 1000;
  localparam logic [19:0] TPP_MIN = 20'h00001;
  localparam logic [19:0] TPP_MAX = 20'hf4240;

  // ==========================================================================
  // Buffer geometry
  // ==========================================================================
  localparam int BUF_POINTS = 100000;
  localparam int NCURVE_MAX = 16;
  localparam int FAST_LANES = 8;
  localparam logic [7:0] LANES_SINGLE = 8'h1f;
  localparam logic [7:0] LANES_DUAL = 8'hff;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_TPP = 8'h08;
  localparam logic [7:0] OFS_LEN = 8'h0c;
  localparam logic [7:0] OFS_CSEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_POINTS = 8'h18;
  localparam logic [7:0] OFS_SWEEPS = 8'h1c;
  localparam logic [7:0] OFS_EFFLEN = 8'h20;
  localparam logic [7:0] OFS_RDADDR = 8'h24;
  localparam logic [7:0] OFS_RDDATA = 8'h28;

  // ==========================================================================
  // Field positions and codes
  // ==========================================================================
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int CTRL_START_LSB = 2;
  localparam int CTRL_STOP_LSB = 4;
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_STOP_BIT = 2;
  localparam int RDADDR_LANE_LSB = 24;
  localparam logic [1:0] START_INT = 2'h0;
  localparam logic [1:0] START_RISE = 2'h1;
  localparam logic [1:0] START_FALL = 2'h2;
  localparam logic [1:0] STOP_INT = 2'h0;
  localparam logic [1:0] STOP_FULL = 2'h1;
  localparam logic [1:0] STOP_RISE = 2'h2;
  localparam logic [1:0] STOP_FALL = 2'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] START_RST = START_INT;
  localparam logic [1:0] STOP_RST = STOP_FULL;
  localparam logic [19:0] TPP_RST = 20'h00001;
  localparam logic [16:0] LEN_RST = 17'h186a0;
  localparam logic [15:0] CSEL_RST = 16'h0001;

  typedef enum logic [1:0] {TCB_IDLE, TCB_ARMED, TCB_RUN} tcb_state_t;

endpackage : tcb_pkg
